// >>> src/rsp_pkg.sv
// Shared constants for the differential-bus serial port.
// Assumes a single 25 MHz processor clock; no software registers.
package rsp_pkg;
    localparam int unsigned CLK_HZ       = 25000000;
    localparam int unsigned BAUD_MIN     = 300;
    localparam int unsigned BAUD_MAX     = 250000;
    // Clocks per bit at the slowest and fastest documented rate
    localparam int unsigned DIV_SLOW     = CLK_HZ / BAUD_MIN;
    localparam int unsigned DIV_FAST     = CLK_HZ / BAUD_MAX;
    localparam int unsigned DIV_W        = 17;
    localparam int unsigned DATA_BITS    = 8;
    localparam int unsigned BIT_IDX_W    = 3;
    localparam int unsigned FIFO_DEPTH   = 32;
    localparam logic [BIT_IDX_W-1:0] LAST_BIT = 3'h7;
    localparam logic START_LEVEL = 1'b0;
    localparam logic STOP_LEVEL  = 1'b1;
    localparam logic IDLE_LEVEL  = 1'b1;
    localparam logic [DIV_W-1:0] DIV_LO = DIV_W'(DIV_FAST);
    localparam logic [DIV_W-1:0] DIV_HI = DIV_W'(DIV_SLOW);
    localparam logic [DIV_W-1:0] CNT_ONE = 17'h00001;

    typedef enum logic [1:0] {RSP_IDLE, RSP_START, RSP_DATA, RSP_STOP} rsp_state_e;
endpackage : rsp_pkg

// >>> src/rsp_fifo.sv
// Synchronous FIFO with registered read data and valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module rsp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
    logic [AW:0]      count_reg, count_next;
    logic             out_valid_reg, out_valid_next;
    logic [WIDTH-1:0] out_data_reg, out_data_next;
    logic             push, pop_mem, load_out;

    // Output register is one of the DEPTH words
    assign in_ready  = ((count_reg + (AW+1)'(out_valid_reg)) != (AW+1)'(DEPTH));
    assign out_valid = out_valid_reg;
    assign out_data  = out_data_reg;

    always_comb begin
        push           = in_valid && in_ready;
        load_out       = !out_valid_reg || out_ready;
        pop_mem        = load_out && (count_reg != '0);
        wr_ptr_next    = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next    = pop_mem ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next     = count_reg + (AW+1)'(push) - (AW+1)'(pop_mem);
        out_valid_next = load_out ? (count_reg != '0) : out_valid_reg;
        out_data_next  = pop_mem ? mem[rd_ptr_reg] : out_data_reg;
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
        if (!rst_n) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            count_reg     <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end else begin
            wr_ptr_reg    <= wr_ptr_next;
            rd_ptr_reg    <= rd_ptr_next;
            count_reg     <= count_next;
            out_valid_reg <= out_valid_next;
            out_data_reg  <= out_data_next;
        end
    end
endmodule : rsp_fifo

// >>> src/rsp_serial_port.sv
// Differential-bus asynchronous serial port: transmitter, receiver,
// background receive buffer and a guarded firmware-image byte path.
// Assumes an external transceiver; line pins arrive asynchronously.
`timescale 1ns/1ps
// Function
// [RULE1] Eight data bits, no parity, one stop
// [RULE2] Bit rate selectable 300 to 250K baud
// [RULE3] Start bit low, stop bit high
// [RULE4] Data sent LSB first after start
// [RULE5] Full duplex paths share one rate generator
// [RULE6] Single-byte mode or background buffered mode
// [RULE7] Direction pin sampled only, never driven
// [RULE8] Slaves turn around themselves when we master
// [RULE9] Module resets while reset held low
// [RULE10] One port for traffic and firmware download
// [RULE11] Images accepted only from programming adapter
// [RULE12] Non-inverting line true, inverting line complement
// [RULE13] Receiver confirms start mid-bit, samples centres
module rsp_serial_port #(
    parameter int unsigned BUF_DEPTH = rsp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    // Configuration
    input  wire logic [rsp_pkg::DIV_W-1:0] baud_div,
    input  wire logic                      buffered_mode,
    input  wire logic                      slave_mode,
    input  wire logic                      fw_mode,
    // Transmit request
    input  wire logic                      tx_valid,
    input  wire logic [7:0]                tx_data,
    output logic                           tx_ready,
    // Receive answer
    output logic                           rx_valid,
    output logic [7:0]                     rx_data,
    input  wire logic                      rx_ready,
    output logic                           rx_overrun,
    output logic                           rx_frame_err,
    // Firmware image bytes
    output logic                           img_valid,
    output logic [7:0]                     img_data,
    output logic                           img_refused,
    // Line pins
    input  wire logic                      line_rx,
    input  wire logic                      turn_pin,
    output logic                           line_a_out,
    output logic                           line_b_out,
    output logic                           line_oe
);
    // Shared rate generator
    logic [rsp_pkg::DIV_W-1:0] div_eff;
    always_comb begin
        if (baud_div < rsp_pkg::DIV_LO) begin
            div_eff = rsp_pkg::DIV_LO; // RULE2
        end else if (baud_div > rsp_pkg::DIV_HI) begin
            div_eff = rsp_pkg::DIV_HI; // RULE2
        end else begin
            div_eff = baud_div; // RULE5
        end
    end

    // Pin synchronisers
    logic rx_s1_reg, rx_s2_reg, rx_prev_reg;
    logic turn_s1_reg, turn_s2_reg;
    always_ff @(posedge clock) begin
        if (!rst_n) begin // RULE9
            rx_s1_reg   <= rsp_pkg::IDLE_LEVEL;
            rx_s2_reg   <= rsp_pkg::IDLE_LEVEL;
            rx_prev_reg <= rsp_pkg::IDLE_LEVEL;
            turn_s1_reg <= 1'b0;
            turn_s2_reg <= 1'b0;
        end else begin
            rx_s1_reg   <= line_rx;
            rx_s2_reg   <= rx_s1_reg;
            rx_prev_reg <= rx_s2_reg;
            turn_s1_reg <= turn_pin; // RULE7
            turn_s2_reg <= turn_s1_reg;
        end
    end

    // Transmitter
    rsp_pkg::rsp_state_e       tx_st_reg, tx_st_next;
    logic [rsp_pkg::DIV_W-1:0] tx_cnt_reg, tx_cnt_next;
    logic [2:0]                tx_bit_reg, tx_bit_next;
    logic [7:0]                tx_sh_reg, tx_sh_next;
    logic                      tx_line_reg, tx_line_next;
    logic                      tx_go, tx_tick;
    // In slave mode the host owns the direction, so only send while it grants
    assign tx_go    = (tx_st_reg == rsp_pkg::RSP_IDLE) && (!slave_mode || turn_s2_reg);
    assign tx_ready = tx_go;
    assign tx_tick  = (tx_cnt_reg == rsp_pkg::CNT_ONE);
    always_comb begin
        tx_st_next   = tx_st_reg;
        tx_cnt_next  = tx_tick ? div_eff : tx_cnt_reg - 1'b1;
        tx_bit_next  = tx_bit_reg;
        tx_sh_next   = tx_sh_reg;
        tx_line_next = tx_line_reg;
        case (tx_st_reg)
            rsp_pkg::RSP_IDLE: begin
                tx_cnt_next  = div_eff;
                tx_line_next = rsp_pkg::IDLE_LEVEL;
                if (tx_valid && tx_go) begin
                    tx_st_next   = rsp_pkg::RSP_START;
                    tx_sh_next   = tx_data;
                    tx_line_next = rsp_pkg::START_LEVEL; // RULE3
                end
            end
            rsp_pkg::RSP_START: begin
                if (tx_tick) begin
                    tx_st_next   = rsp_pkg::RSP_DATA;
                    tx_bit_next  = '0;
                    tx_line_next = tx_sh_reg[0]; // RULE4
                    tx_sh_next   = {1'b0, tx_sh_reg[7:1]};
                end
            end
            rsp_pkg::RSP_DATA: begin
                if (tx_tick) begin
                    if (tx_bit_reg == rsp_pkg::LAST_BIT) begin // RULE1
                        tx_st_next   = rsp_pkg::RSP_STOP;
                        tx_line_next = rsp_pkg::STOP_LEVEL; // RULE3
                    end else begin
                        tx_bit_next  = tx_bit_reg + 1'b1;
                        tx_line_next = tx_sh_reg[0]; // RULE4
                        tx_sh_next   = {1'b0, tx_sh_reg[7:1]};
                    end
                end
            end
            default: begin
                if (tx_tick) begin // RULE1
                    tx_st_next = rsp_pkg::RSP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_st_reg   <= rsp_pkg::RSP_IDLE;
            tx_cnt_reg  <= rsp_pkg::DIV_LO;
            tx_bit_reg  <= '0;
            tx_sh_reg   <= '0;
            tx_line_reg <= rsp_pkg::IDLE_LEVEL;
        end else begin
            tx_st_reg   <= tx_st_next;
            tx_cnt_reg  <= tx_cnt_next;
            tx_bit_reg  <= tx_bit_next;
            tx_sh_reg   <= tx_sh_next;
            tx_line_reg <= tx_line_next;
        end
    end

    assign line_a_out = tx_line_reg; // RULE12
    assign line_b_out = !tx_line_reg; // RULE12
    // As master the driver is ours only while a frame is out; slaves turn round alone
    assign line_oe = slave_mode ? turn_s2_reg : (tx_st_reg != rsp_pkg::RSP_IDLE); // RULE7 RULE8

    // Receiver
    rsp_pkg::rsp_state_e       rx_st_reg, rx_st_next;
    logic [rsp_pkg::DIV_W-1:0] rx_cnt_reg, rx_cnt_next;
    logic [2:0]                rx_bit_reg, rx_bit_next;
    logic [7:0]                rx_sh_reg, rx_sh_next;
    logic                      rx_done, rx_ferr, rx_tick;
    logic                      rx_adapter_reg, rx_adapter_next;
    assign rx_tick = (rx_cnt_reg == rsp_pkg::CNT_ONE);
    always_comb begin
        rx_st_next      = rx_st_reg;
        rx_cnt_next     = rx_tick ? div_eff : rx_cnt_reg - 1'b1;
        rx_bit_next     = rx_bit_reg;
        rx_sh_next      = rx_sh_reg;
        rx_adapter_next = rx_adapter_reg;
        rx_done         = 1'b0;
        rx_ferr         = 1'b0;
        case (rx_st_reg)
            rsp_pkg::RSP_IDLE: begin
                rx_cnt_next = {1'b0, div_eff[rsp_pkg::DIV_W-1:1]};
                if (rx_prev_reg && !rx_s2_reg) begin // RULE13
                    rx_st_next      = rsp_pkg::RSP_START;
                    rx_adapter_next = turn_s2_reg;
                end
            end
            rsp_pkg::RSP_START: begin
                if (rx_tick) begin
                    // A glitch shorter than half a bit is dropped here
                    rx_st_next  = (rx_s2_reg == rsp_pkg::START_LEVEL) ?
                                  rsp_pkg::RSP_DATA : rsp_pkg::RSP_IDLE; // RULE13
                    rx_bit_next = '0;
                end
            end
            rsp_pkg::RSP_DATA: begin
                if (rx_tick) begin
                    rx_sh_next = {rx_s2_reg, rx_sh_reg[7:1]}; // RULE4 RULE13
                    if (rx_bit_reg == rsp_pkg::LAST_BIT) begin
                        rx_st_next = rsp_pkg::RSP_STOP; // RULE1
                    end else begin
                        rx_bit_next = rx_bit_reg + 1'b1;
                    end
                end
            end
            default: begin
                if (rx_tick) begin
                    rx_st_next = rsp_pkg::RSP_IDLE;
                    rx_done    = (rx_s2_reg == rsp_pkg::STOP_LEVEL); // RULE3
                    rx_ferr    = (rx_s2_reg != rsp_pkg::STOP_LEVEL);
                end
            end
        endcase
        rx_adapter_next = rx_adapter_next && turn_s2_reg;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_st_reg      <= rsp_pkg::RSP_IDLE;
            rx_cnt_reg     <= rsp_pkg::DIV_LO;
            rx_bit_reg     <= '0;
            rx_sh_reg      <= '0;
            rx_adapter_reg <= 1'b0;
        end else begin
            rx_st_reg      <= rx_st_next;
            rx_cnt_reg     <= rx_cnt_next;
            rx_bit_reg     <= rx_bit_next;
            rx_sh_reg      <= rx_sh_next;
            rx_adapter_reg <= rx_adapter_next;
        end
    end

    // Byte routing: firmware path, single-byte holder or buffer
    logic       to_img, to_buf, to_one;
    logic       one_valid_reg, one_valid_next;
    logic [7:0] one_data_reg, one_data_next;
    logic       img_valid_reg, img_valid_next;
    logic [7:0] img_data_reg, img_data_next;
    logic       refused_reg, refused_next;
    logic       ovr_reg, ovr_next;
    logic       ferr_reg, ferr_next;
    logic       buf_in_ready, buf_out_valid, buf_out_ready;
    logic [7:0] buf_out_data;

    always_comb begin
        to_img         = rx_done && fw_mode; // RULE10
        to_buf         = rx_done && !fw_mode && buffered_mode; // RULE6
        to_one         = rx_done && !fw_mode && !buffered_mode; // RULE6
        // Turn pin held high for the whole byte marks the adapter
        img_valid_next = to_img && rx_adapter_reg; // RULE11
        refused_next   = to_img && !rx_adapter_reg; // RULE11
        img_data_next  = img_valid_next ? rx_sh_reg : img_data_reg;
        one_valid_next = one_valid_reg && !(rx_ready && !buffered_mode);
        one_data_next  = one_data_reg;
        // The line cannot be stalled, so a full holder or buffer drops the byte
        ovr_next       = (to_buf && !buf_in_ready) || (to_one && one_valid_next);
        if (to_one && !one_valid_next) begin
            one_valid_next = 1'b1;
            one_data_next  = rx_sh_reg;
        end
        ferr_next      = rx_ferr;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            one_valid_reg <= 1'b0;
            one_data_reg  <= '0;
            img_valid_reg <= 1'b0;
            img_data_reg  <= '0;
            refused_reg   <= 1'b0;
            ovr_reg       <= 1'b0;
            ferr_reg      <= 1'b0;
        end else begin
            one_valid_reg <= one_valid_next;
            one_data_reg  <= one_data_next;
            img_valid_reg <= img_valid_next;
            img_data_reg  <= img_data_next;
            refused_reg   <= refused_next;
            ovr_reg       <= ovr_next;
            ferr_reg      <= ferr_next;
        end
    end

    rsp_fifo #(
        .WIDTH (rsp_pkg::DATA_BITS),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buf (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (to_buf),
        .in_data   (rx_sh_reg),
        .in_ready  (buf_in_ready),
        .out_valid (buf_out_valid),
        .out_data  (buf_out_data),
        .out_ready (buf_out_ready)
    );

    assign buf_out_ready = rx_ready && buffered_mode; // RULE6
    assign rx_valid      = buffered_mode ? buf_out_valid : one_valid_reg;
    assign rx_data       = buffered_mode ? buf_out_data : one_data_reg;
    assign rx_overrun    = ovr_reg;
    assign rx_frame_err  = ferr_reg;
    assign img_valid     = img_valid_reg;
    assign img_data      = img_data_reg;
    assign img_refused   = refused_reg;
endmodule : rsp_serial_port

// >>> sim/rsp_serial_port_properties.sv
// Checker for the serial port top: framing, timing and the direction pin.
// Assumes baud_div in range and steady while a frame is out.
`timescale 1ns/1ps
module rsp_port_checker (
    // Clock and reset
    input wire logic                      clock,
    input wire logic                      rst_n,
    // Watched ports
    input wire logic [rsp_pkg::DIV_W-1:0] baud_div,
    input wire logic                      slave_mode,
    input wire logic                      tx_valid,
    input wire logic [7:0]                tx_data,
    input wire logic                      tx_ready,
    input wire logic                      rx_valid,
    input wire logic [7:0]                rx_data,
    input wire logic                      rx_ready,
    input wire logic                      turn_pin,
    input wire logic                      line_a_out,
    input wire logic                      line_b_out,
    input wire logic                      line_oe
);
    logic        frm_reg, frm_next;
    logic [20:0] cnt_reg, cnt_next, bit_n, pos;
    logic [7:0]  dat_reg, dat_next;
    // Cycles since the take, counted while the transmitter is busy
    always_comb begin
        frm_next = tx_ready ? tx_valid : frm_reg;
        cnt_next = tx_ready ? 21'h0 : cnt_reg + 21'h1;
        dat_next = (tx_valid && tx_ready) ? tx_data : dat_reg;
        bit_n    = cnt_reg / 21'(baud_div);
        pos      = cnt_reg % 21'(baud_div);
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            frm_reg <= 1'b0;
            cnt_reg <= 21'h0;
            dat_reg <= 8'h00;
        end else begin
            frm_reg <= frm_next;
            cnt_reg <= cnt_next;
            dat_reg <= dat_next;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    sequence s_take;
        tx_valid && tx_ready;
    endsequence
    sequence s_mid_bit;
        frm_reg && !tx_ready && pos == 21'(baud_div / 2);
    endsequence
    sequence s_turn_low;
        (slave_mode && !turn_pin) [*3];
    endsequence
    sequence s_turn_high;
        (slave_mode && turn_pin) [*3];
    endsequence
    chk_start_low: assert property (disable iff (!rst_n)
        s_take |=> !line_a_out && !tx_ready) else $error("start bit missing");
    chk_data_lsb: assert property (disable iff (!rst_n)
        s_mid_bit ##0 (bit_n inside {[1:8]}) |-> line_a_out == dat_reg[3'(bit_n - 21'h1)])
        else $error("data bit out of order");
    chk_stop_high: assert property (disable iff (!rst_n)
        s_mid_bit ##0 bit_n == 21'h9 |-> line_a_out) else $error("stop bit not high");
    chk_frame_len: assert property (disable iff (!rst_n)
        $rose(tx_ready) && frm_reg |-> cnt_reg == 21'(10 * baud_div))
        else $error("frame length wrong");
    chk_line_compl: assert property (disable iff (!rst_n)
        line_b_out == !line_a_out) else $error("lines not complementary");
    chk_oe_master: assert property (disable iff (!rst_n)
        !slave_mode && frm_reg && !tx_ready |-> line_oe) else $error("driver off in frame");
    chk_slave_refuse: assert property (disable iff (!rst_n)
        s_turn_low |-> !tx_ready && !line_oe) else $error("sent without turn");
    chk_oe_follow: assert property (disable iff (!rst_n)
        s_turn_high |-> line_oe) else $error("driver ignores turn");
    chk_rx_hold: assert property (disable iff (!rst_n)
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("rx byte lost");
    chk_reset_idle: assert property (
        !rst_n |=> line_a_out && !rx_valid) else $error("not idle in reset");
endmodule : rsp_port_checker

bind rsp_serial_port rsp_port_checker rsp_port_checker_i (
    .clock(clock), .rst_n(rst_n), .baud_div(baud_div), .slave_mode(slave_mode),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .turn_pin(turn_pin), .line_a_out(line_a_out),
    .line_b_out(line_b_out), .line_oe(line_oe));

// >>> sim/rsp_remote_station.sv
// Remote bus station: sends framed bytes and decodes the port's lines.
// Assumes send_go pulses one cycle and send_byte holds for the frame.
`timescale 1ns/1ps
module rsp_remote_station (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // Send request, div clocks per bit
    input wire logic [16:0] div,
    input wire logic        send_go,
    input wire logic [7:0]  send_byte,
    input wire logic        send_stop,
    output logic            send_busy,
    // Decoded bytes
    output logic [7:0]      got_byte,
    output logic            got_stop,
    output int              got_cnt,
    // Bus lines, idle high by the bus pull-up
    output logic            line_out,
    input wire logic        line_a,
    input wire logic        line_b,
    input wire logic        line_en
);
    logic       rx_bit;
    logic [7:0] shift;
    // Released bus reads high through the pull-up
    assign rx_bit = line_en ? (line_a & ~line_b) : 1'b1;
    initial begin
        line_out = 1'b1;
        send_busy = 1'b0;
        got_cnt = 0;
    end
    // Own turnaround, no direction signal needed
    always begin
        @(posedge clock);
        if (send_go) begin
            send_busy <= 1'b1;
            line_out  <= 1'b0;
            repeat (div) @(posedge clock);
            for (int i = 0; i < 8; i++) begin
                line_out <= send_byte[i];
                repeat (div) @(posedge clock);
            end
            line_out  <= send_stop;
            repeat (div) @(posedge clock);
            line_out  <= 1'b1;
            send_busy <= 1'b0;
        end
    end
    // Mid-bit sampling; ignores the line while the port is in reset
    always begin
        @(posedge clock);
        if (rst_n && !rx_bit) begin
            repeat (div / 2) @(posedge clock);
            for (int j = 0; j < 8; j++) begin
                repeat (div) @(posedge clock);
                shift[j] = rx_bit;
            end
            repeat (div) @(posedge clock);
            got_stop <= rx_bit;
            got_byte <= shift;
            got_cnt  <= got_cnt + 1;
        end
    end
endmodule : rsp_remote_station

// >>> sim/rsp_serial_port_tb_top.sv
// Self-checking bench: port against a remote station model.
// Assumes a 25 MHz clock and 100 clocks per bit, 200 in the slave test.
`timescale 1ns/1ps
module rsp_serial_port_tb_top;
    localparam logic [16:0] DIV = 17'h00064;
    logic [16:0] div_sel = DIV;
    logic       clock, rst_n = 1'b0, buffered_mode = 1'b0, slave_mode = 1'b0;
    logic       fw_mode = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0, turn_pin = 1'b0;
    logic       send_go = 1'b0, send_stop = 1'b1;
    logic [7:0] tx_data = 8'h00, send_byte = 8'h00, rx_data, img_data, got_byte;
    logic       tx_ready, rx_valid, rx_overrun, rx_frame_err, img_valid, img_refused;
    logic       line_a_out, line_b_out, line_oe, line_rx, send_busy, got_stop;
    int         got_cnt, error_cnt = 0, total_checks = 0, ovr_n = 0, ferr_n = 0;
    int         img_n = 0, ref_n = 0, c;
    rsp_serial_port rsp_serial_port_i (
        .clock(clock), .rst_n(rst_n), .baud_div(div_sel), .buffered_mode(buffered_mode),
        .slave_mode(slave_mode), .fw_mode(fw_mode), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .rx_overrun(rx_overrun), .rx_frame_err(rx_frame_err), .img_valid(img_valid),
        .img_data(img_data), .img_refused(img_refused), .line_rx(line_rx),
        .turn_pin(turn_pin), .line_a_out(line_a_out), .line_b_out(line_b_out),
        .line_oe(line_oe));
    rsp_remote_station rsp_remote_station_i (
        .clock(clock), .rst_n(rst_n), .div(div_sel), .send_go(send_go), .send_byte(send_byte),
        .send_stop(send_stop), .send_busy(send_busy), .got_byte(got_byte),
        .got_stop(got_stop), .got_cnt(got_cnt), .line_out(line_rx), .line_a(line_a_out),
        .line_b(line_b_out), .line_en(line_oe));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Pulse counters, so scenarios compare counts rather than catch pulses
    always @(posedge clock) begin
        ovr_n  <= ovr_n + int'(rx_overrun === 1'b1);
        ferr_n <= ferr_n + int'(rx_frame_err === 1'b1);
        img_n  <= img_n + int'(img_valid === 1'b1);
        ref_n  <= ref_n + int'(img_refused === 1'b1);
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic station_send(input logic [7:0] b, input logic stop);
        int n = 0;
        @(posedge clock);
        send_go   <= 1'b1;
        send_byte <= b;
        send_stop <= stop;
        @(posedge clock);
        send_go <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (send_busy && n < 2000);
        if (send_busy) error_cnt++;
        repeat (4) @(posedge clock);
    endtask : station_send
    task automatic port_send(input logic [7:0] b);
        int n = 0;
        tx_valid <= 1'b1;
        tx_data  <= b;
        do begin
            @(posedge clock);
            n++;
        end while (tx_ready !== 1'b1 && n < 3000);
        if (tx_ready !== 1'b1) error_cnt++;
        tx_valid <= 1'b0;
        n = 0;
        while (got_cnt == c && n < 3000) begin
            @(posedge clock);
            n++;
        end
        if (got_cnt == c) error_cnt++;
        check("line_byte", b, got_byte);
        check("line_stop", 8'h01, {7'h0, got_stop});
        c = got_cnt;
    endtask : port_send
    task automatic port_read(input logic [7:0] exp);
        int n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (rx_valid !== 1'b1 && n < 3000);
        if (rx_valid !== 1'b1) error_cnt++;
        check("rx_data", exp, rx_data);
        rx_ready <= 1'b1;
        @(posedge clock);
        rx_ready <= 1'b0;
    endtask : port_read
    task automatic t_duplex;
        @(posedge clock);
        fork
            station_send(8'h3c, 1'b1);
            port_send(8'ha5);
        join
        port_read(8'h3c);
        $display("duplex test done");
    endtask : t_duplex
    task automatic t_rx_modes;
        int o = ovr_n;
        station_send(8'h11, 1'b1);
        station_send(8'h22, 1'b1);
        check("overrun_single", 8'h01, 8'(ovr_n - o));
        port_read(8'h11);
        buffered_mode <= 1'b1;
        o = ovr_n;
        for (int i = 0; i < 34; i++) station_send(8'(i), 1'b1);
        check("overrun_full", 8'h01, 8'(ovr_n > o));
        for (int k = 0; k < 32; k++) port_read(8'(k));
        repeat (3) @(posedge clock);
        check("overrun_count", 8'h02, 8'(ovr_n - o));
        repeat (4) @(posedge clock);
        check("rx_empty", 8'h00, {7'h0, rx_valid});
        buffered_mode <= 1'b0;
        o = ferr_n;
        station_send(8'h77, 1'b0);
        check("frame_err", 8'h01, 8'(ferr_n - o));
        check("rx_dropped", 8'h00, {7'h0, rx_valid});
        $display("receive test done");
    endtask : t_rx_modes
    task automatic t_image;
        int v = img_n;
        int r = ref_n;
        fw_mode  <= 1'b1;
        turn_pin <= 1'b1;
        station_send(8'h5a, 1'b1);
        check("img_count", 8'h01, 8'(img_n - v));
        check("img_data", 8'h5a, img_data);
        turn_pin <= 1'b0;
        station_send(8'h6b, 1'b1);
        check("img_refused", 8'h01, 8'(ref_n - r));
        check("img_kept", 8'h01, 8'(img_n - v));
        fw_mode <= 1'b0;
        $display("image test done");
    endtask : t_image
    task automatic t_slave;
        slave_mode <= 1'b1;
        div_sel    <= 17'h000c8;
        tx_valid   <= 1'b1;
        tx_data    <= 8'hc3;
        repeat (400) @(posedge clock);
        check("tx_ready_refused", 8'h00, {7'h0, tx_ready});
        check("oe_off", 8'h00, {7'h0, line_oe});
        turn_pin <= 1'b1;
        port_send(8'hc3);
        check("oe_on", 8'h01, {7'h0, line_oe});
        repeat (200) @(posedge clock);
        check("tx_idle", 8'h01, {7'h0, tx_ready});
        turn_pin   <= 1'b0;
        slave_mode <= 1'b0;
        div_sel    <= DIV;
        $display("slave test done");
    endtask : t_slave
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        print_verdict();
    end
    initial begin
        c = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_duplex();
        t_rx_modes();
        t_image();
        t_slave();
        print_verdict();
    end
endmodule : rsp_serial_port_tb_top
